// *** verif/cpu_core_model.sv ***
// cpu core model that acknowledges vectored requests
`timescale 1ns/1ps
module cpu_core_model
  (
    // clock, reset, control
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_en,
    // request side
    input  wire logic i_irq_req,
    output logic      o_ack
  );
  logic [1:0] wait_q;
  // one ack pulse, then hold off while the level settles
  always_ff @(posedge i_clk)
  begin
    o_ack <= 1'b0;
    if (!i_rst_n)
      wait_q <= 2'h0;
    else if (wait_q != 2'h0)
      wait_q <= wait_q - 2'h1;
    else if (i_en && i_irq_req)
    begin
      o_ack  <= 1'b1;
      wait_q <= 2'h3;
    end
  end
endmodule : cpu_core_model

// *** verif/irq_ctrl_checker.sv ***
// port assertions for the interrupt controller
`timescale 1ns/1ps
module irq_ctrl_checker
  import irq_ctrl_pkg::*;
  (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [3:0]  i_trap_evt,
    input wire logic        i_irq_ack,
    input wire logic        o_irq_req,
    input wire logic [7:0]  o_irq_vector,
    input wire logic [3:0]  o_irq_level,
    input wire logic [3:0]  o_cpu_level,
    input wire logic        o_trap_req,
    input wire logic        o_alt_vector_table
  );
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic nest_q;
  // mirror of the nesting disable bit
  always_ff @(posedge i_clk)
    if (!i_rst_n) nest_q <= 1'b0;
    else if (i_wr && i_addr == OFF_GLOBAL_A) nest_q <= i_wdata[BIT_NEST_DIS];
  unmapped_read_a: assert property (i_rd && i_addr == 8'hfe |=> o_rdata == 16'h0)
    else $error("unmapped read not zero");
  req_above_a: assert property ($rose(o_irq_req) |-> o_irq_level > o_cpu_level)
    else $error("request at or below cpu level");
  ack_level_a: assert property (o_irq_req && i_irq_ack && !i_wr |=>
    o_cpu_level[2:0] == ($past(nest_q) ? PRIO_MAX : $past(o_irq_level[2:0])))
    else $error("cpu level wrong after ack");
  alt_table_a: assert property (i_wr && i_addr == OFF_GLOBAL_B |=>
    o_alt_vector_table == $past(i_wdata[BIT_ALT_TABLE])) else $error("alt table bit wrong");
  trap_set_a: assert property (|i_trap_evt |=> o_trap_req)
    else $error("trap event not flagged");
  trap_top_a: assert property (o_cpu_level[3] == o_trap_req)
    else $error("top level bit differs from trap");
  alu_level_a: assert property (i_wr && i_addr == OFF_ALU_STATUS |=>
    o_cpu_level[2:0] == $past(i_wdata[7:5])) else $error("cpu level write lost");
  vector_hold_a: assert property (!o_irq_req |-> $stable(o_irq_vector))
    else $error("vector moved without request");
  cover property (o_irq_req && i_irq_ack);
  cover property (o_trap_req);
  cover property ($rose(o_alt_vector_table));
endmodule : irq_ctrl_checker
bind prioritized_irq_controller irq_ctrl_checker chk_i (.i_clk, .i_rst_n, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_trap_evt, .i_irq_ack, .o_irq_req, .o_irq_vector, .o_irq_level,
  .o_cpu_level, .o_trap_req, .o_alt_vector_table);

// *** verif/tb_top.sv ***
// register-level testbench for the interrupt controller
`timescale 1ns/1ps
module tb_top;
  import irq_ctrl_pkg::*;
  logic i_clk, i_rst_n, i_wr, i_rd, i_ext_req0, ack, o_irq_req, o_trap_req, o_alt, o_irq, cpu_en;
  logic [7:0] i_addr, o_irq_vector;
  logic [15:0] i_wdata, o_rdata, i_evt_bank0, i_evt_bank5;
  logic [3:0] i_trap_evt, o_irq_level, o_cpu_level;
  int errors, tests_run;
  prioritized_irq_controller dut (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_evt_bank0, .i_evt_bank5, .i_ext_req0, .i_trap_evt, .i_irq_ack(ack),
    .o_irq_req, .o_irq_vector, .o_irq_level, .o_cpu_level, .o_trap_req,
    .o_alt_vector_table(o_alt), .o_irq);
  cpu_core_model cpu (.i_clk, .i_rst_n, .i_en(cpu_en), .i_irq_req(o_irq_req), .o_ack(ack));
  // 100 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask : rdc
  task automatic settle();
    repeat (3) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic ev(input logic [15:0] v);
    @(posedge i_clk);
    i_evt_bank5 <= v;
    @(posedge i_clk);
    i_evt_bank5 <= 16'h0;
  endtask : ev
  task automatic wrap_up();
    $display("comparisons %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // ****
  // scenarios
  // ****
  initial
  begin
    {i_rst_n, i_wr, i_rd, i_ext_req0, cpu_en, i_addr, i_wdata, i_trap_evt} = '0;
    {i_evt_bank0, i_evt_bank5} = '0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdc(OFF_PRIO_GRP3, RST_PRIO_GRP3);
    rdc(OFF_PRIO_UART3, RST_PRIO_UART3);
    wr(OFF_FLAGS5, 16'hffff);
    rdc(OFF_FLAGS5, MASK_BANK5);
    wr(OFF_PRIO_UART3, 16'hffff);
    rdc(OFF_PRIO_UART3, MASK_PRIO_UART3);
    rdc(8'hfe, 16'h0000);
    wr(OFF_FLAGS5, 16'h0000);
    rdc(OFF_FLAGS5, 16'h0000);
    ev(16'h0008);
    rdc(OFF_FLAGS5, 16'h0008);
    chk(16'(o_irq_req), 16'h0);
    wr(OFF_ENABLE5, 16'h000c);
    // every priority code on one source
    for (int p = 0; p < 8; p++)
    begin
      wr(OFF_PRIO_UART3, 16'(p) << 12);
      settle();
      chk(16'(o_irq_req), 16'(p != 0));
      if (p != 0) chk(16'(o_irq_level), 16'(p));
    end
    chk(16'(o_irq_vector), 16'h0053);
    ev(16'h0004);
    wr(OFF_PRIO_UART3, 16'h7700);
    settle();
    chk(16'(o_irq_vector), 16'h0052);
    wr(OFF_PRIO_UART3, 16'h7600);
    settle();
    chk(16'(o_irq_vector), 16'h0053);
    wr(OFF_ALU_STATUS, 16'h00e0);
    settle();
    chk(16'(o_irq_req), 16'h0);
    wr(OFF_FLAGS5, 16'h0008);
    wr(OFF_PRIO_UART3, 16'h5000);
    wr(OFF_ALU_STATUS, 16'h0000);
    wr(OFF_EVT_EN, 16'h0001);
    settle();
    chk(16'(o_irq), 16'h1);
    wr(OFF_EVT_CLR, 16'h0003);
    settle();
    chk(16'(o_irq), 16'h0);
    cpu_en <= 1'b1;
    repeat (6) @(posedge i_clk);
    cpu_en <= 1'b0;
    chk(16'(o_cpu_level), 16'h5);
    rdc(OFF_LATCHED, 16'h5053);
    wr(OFF_GLOBAL_A, 16'h8000);
    wr(OFF_ALU_STATUS, 16'h0000);
    cpu_en <= 1'b1;
    repeat (6) @(posedge i_clk);
    cpu_en <= 1'b0;
    chk(16'(o_cpu_level), 16'h7);
    i_trap_evt <= 4'h1;
    @(posedge i_clk);
    i_trap_evt <= 4'h0;
    wr(OFF_CORE_CTRL, 16'h0000);
    rdc(OFF_CORE_CTRL, 16'h0008);
    rdc(OFF_GLOBAL_A, 16'h8002);
    wr(OFF_GLOBAL_A, 16'h0000);
    settle();
    chk(16'(o_trap_req), 16'h0);
    wr(OFF_GLOBAL_B, 16'hffff);
    rdc(OFF_GLOBAL_B, MASK_GLOBAL_B);
    chk(16'(o_alt), 16'h1);
    i_ext_req0 <= 1'b1;
    rdc(OFF_FLAGS0, 16'h0000);
    i_ext_req0 <= 1'b0;
    rdc(OFF_FLAGS0, 16'h0001);
    wrap_up();
  end
  // watchdog against a hang
  initial
  begin
    repeat (3000) @(posedge i_clk);
    errors++;
    wrap_up();
  end
endmodule : tb_top

// *** verilog/irq_ctrl_pkg.sv ***
// constants, offsets and field layouts of the prioritized interrupt controller
//
// Function
// - hardware sets request flag, software write clears
// - request passes only with its enable set
// - each source has 3-bit priority, eight levels
// - priority code 111 highest, 000 disables source
// - bits allocated in ascending vector order
// - first global control holds nesting disable
// - first global control holds trap status flags
// - second control: external request edge, alternate table
// - latch vector number and level into status
// - latched level equals pending request priority
// - cpu level in alu status bits 7:5
// - core control top level bit is read-only
// - flag register five fixed bit layout
// - group three priority fields, reset 100
// - uart three priority fields, reset 100
package irq_ctrl_pkg;

  // ****************************************************************
  // bus and sizes
  // ****************************************************************
  localparam int          ADDR_W  = 8;
  localparam int          DATA_W  = 16;
  localparam int          N_SLOT  = 32;
  localparam int          PRIO_W  = 3;
  localparam int          LVL_W   = 4;
  localparam int          N_TRAP  = 4;

  // ****************************************************************
  // register offsets (byte addresses of 16-bit words)
  // ****************************************************************
  localparam logic [7:0]  OFF_GLOBAL_A    = 8'h00;
  localparam logic [7:0]  OFF_GLOBAL_B    = 8'h02;
  localparam logic [7:0]  OFF_FLAGS0      = 8'h04;
  localparam logic [7:0]  OFF_FLAGS5      = 8'h06;
  localparam logic [7:0]  OFF_ENABLE0     = 8'h08;
  localparam logic [7:0]  OFF_ENABLE5     = 8'h0a;
  localparam logic [7:0]  OFF_PRIO0       = 8'h0c;
  localparam logic [7:0]  OFF_PRIO_GRP3   = 8'h0e;
  localparam logic [7:0]  OFF_PRIO_UART3  = 8'h10;
  localparam logic [7:0]  OFF_PRIO5A      = 8'h12;
  localparam logic [7:0]  OFF_PRIO5B      = 8'h14;
  localparam logic [7:0]  OFF_LATCHED     = 8'h16;
  localparam logic [7:0]  OFF_ALU_STATUS  = 8'h18;
  localparam logic [7:0]  OFF_CORE_CTRL   = 8'h1a;
  localparam logic [7:0]  OFF_EVT_STAT    = 8'h1c;
  localparam logic [7:0]  OFF_EVT_CLR     = 8'h1e;
  localparam logic [7:0]  OFF_EVT_EN      = 8'h20;

  // ****************************************************************
  // implemented-bit masks
  // ****************************************************************
  localparam logic [15:0] MASK_GLOBAL_A   = 16'h801e;
  localparam logic [15:0] MASK_GLOBAL_B   = 16'h0101;
  localparam logic [15:0] MASK_BANK0      = 16'h000f;
  localparam logic [15:0] MASK_BANK5      = 16'h0fbe;
  localparam logic [15:0] MASK_PRIO0      = 16'h0007;
  localparam logic [15:0] MASK_PRIO_GRP3  = 16'h0777;
  localparam logic [15:0] MASK_PRIO_UART3 = 16'h7770;
  localparam logic [15:0] MASK_PRIO5A     = 16'h7777;
  localparam logic [15:0] MASK_PRIO5B     = 16'h0777;
  localparam logic [15:0] MASK_ALU_STATUS = 16'h00e0;
  localparam logic [15:0] MASK_EVT        = 16'h0003;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] RST_ZERO        = 16'h0000;
  localparam logic [15:0] RST_PRIO0       = 16'h0004;
  localparam logic [15:0] RST_PRIO_GRP3   = 16'h0444;
  localparam logic [15:0] RST_PRIO_UART3  = 16'h4440;
  localparam logic [15:0] RST_PRIO5A      = 16'h4444;
  localparam logic [15:0] RST_PRIO5B      = 16'h0444;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int          BIT_NEST_DIS    = 15;
  localparam int          BIT_TRAP_LO     = 1;
  localparam int          BIT_EXT0_FALL   = 0;
  localparam int          BIT_ALT_TABLE   = 8;
  localparam int          BIT_LVL_LO      = 5;
  localparam int          BIT_LVL_TOP     = 3;
  localparam int          EVT_REQUEST     = 0;
  localparam int          EVT_TRAP        = 1;
  localparam logic [7:0]  VEC_BANK5_BASE  = 8'h50;
  localparam logic [2:0]  PRIO_MAX        = 3'h7;
  localparam logic [2:0]  PRIO_OFF        = 3'h0;

endpackage : irq_ctrl_pkg

// *** verilog/prioritized_irq_controller.sv ***
// prioritized vectored interrupt controller with register port
`timescale 1ns/1ps

module prioritized_irq_controller
  (
    // clock and reset
    input  wire logic                              i_clk,
    input  wire logic                              i_rst_n,
    // register port
    input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [irq_ctrl_pkg::DATA_W-1:0]   i_wdata,
    input  wire logic                              i_wr,
    input  wire logic                              i_rd,
    output logic      [irq_ctrl_pkg::DATA_W-1:0]   o_rdata,
    // source events, one-cycle pulses
    input  wire logic [15:0]                       i_evt_bank0,
    input  wire logic [15:0]                       i_evt_bank5,
    input  wire logic                              i_ext_req0,
    input  wire logic [irq_ctrl_pkg::N_TRAP-1:0]   i_trap_evt,
    // cpu side
    input  wire logic                              i_irq_ack,
    output logic                                   o_irq_req,
    output logic      [7:0]                        o_irq_vector,
    output logic      [irq_ctrl_pkg::LVL_W-1:0]    o_irq_level,
    output logic      [irq_ctrl_pkg::LVL_W-1:0]    o_cpu_level,
    output logic                                   o_trap_req,
    output logic                                   o_alt_vector_table,
    // controller event interrupt
    output logic                                   o_irq
  );
  import irq_ctrl_pkg::*;

  // ****************************************************************
  // register map and behaviour
  // ****************************************************************
  // 0x00 global control a: nesting disable, trap flags
  // 0x02 global control b: alt table, ext0 edge polarity
  // 0x04 request flags bank 0, bits 3:0
  // 0x06 request flags bank 5, fixed layout
  // 0x08 source enables bank 0
  // 0x0a source enables bank 5
  // 0x0c priority of ext request 0
  // 0x0e priority group 3: dma1, converter, uart one tx
  // 0x10 priority uart three: tx, rx, error
  // 0x12 priority group 5a: two-wire, uart four err/rx
  // 0x14 priority group 5b: uart four tx, serial three
  // 0x16 latched status: level and vector, read only
  // 0x18 alu status: cpu level in bits 7:5
  // 0x1a core control: top level bit, read only
  // 0x1c event status, sticky, read only
  // 0x1e event clear, write one to clear, reads zero
  // 0x20 event enable for the o_irq level output
  //
  // flags: a set pulse beats a written zero
  // trap flags: same rule, inside global control a
  // any trap flag lifts the cpu level above 7
  // so no user source can ever win against a trap
  //
  // arbitration: highest priority first
  // ties: lowest vector number wins
  // candidate must exceed the full 4-bit cpu level
  // code 000 takes a source out of arbitration
  // unused slots tie their priority to off
  //
  // request output lags the candidate by one cycle
  // vector and level latched while a winner exists
  // values hold once the winner goes away
  //
  // acknowledge raises the cpu level to the latched one
  // with nesting disabled it goes straight to 7
  // a level write in the same cycle beats the ack
  //
  // acks while the request is low are ignored
  // lowering the level re-arms older requests
  // read data is zero outside a read cycle
  // all inputs taken as synchronous to i_clk
  // reset is synchronous, active low

  // ****************************************************************
  // helpers
  // ****************************************************************

  // address match for one register
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // slot index to vector number, bank 0 then bank 5
  function automatic logic [7:0] vec_of(input logic [4:0] slot);
    vec_of = slot[4] ? (VEC_BANK5_BASE + {4'h0, slot[3:0]}) : {4'h0, slot[3:0]};
  endfunction : vec_of

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] global_irq_ctrl_a_q, global_irq_ctrl_a_d;
  logic [15:0] global_irq_ctrl_b_q;
  logic [15:0] irq_flags_group0_q, irq_flags_group0_d;
  logic [15:0] irq_flags_group5_q, irq_flags_group5_d;
  logic [15:0] irq_enable_group0_q;
  logic [15:0] irq_enable_group5_q;
  logic [15:0] priority_ctrl_group0_q;
  logic [15:0] priority_ctrl_group3_q;
  logic [15:0] priority_ctrl_uart_three_q;
  logic [15:0] priority_ctrl_group5a_q;
  logic [15:0] priority_ctrl_group5b_q;
  logic [7:0]  latched_vector_number_q;
  logic [3:0]  latched_new_level_q;
  logic [2:0]  cpu_priority_level_q, cpu_priority_level_d;
  logic [15:0] evt_stat_q, evt_stat_d;
  logic [15:0] evt_en_q;
  logic        req_q;
  logic        ext_prev_q;
  logic [15:0] rdata_q;

  // ****************************************************************
  // write decode
  // ****************************************************************
  wire wr_global_a  = i_wr & hit(i_addr, OFF_GLOBAL_A);
  wire wr_global_b  = i_wr & hit(i_addr, OFF_GLOBAL_B);
  wire wr_flags0    = i_wr & hit(i_addr, OFF_FLAGS0);
  wire wr_flags5    = i_wr & hit(i_addr, OFF_FLAGS5);
  wire wr_enable0   = i_wr & hit(i_addr, OFF_ENABLE0);
  wire wr_enable5   = i_wr & hit(i_addr, OFF_ENABLE5);
  wire wr_prio0     = i_wr & hit(i_addr, OFF_PRIO0);
  wire wr_prio_grp3 = i_wr & hit(i_addr, OFF_PRIO_GRP3);
  wire wr_prio_u3   = i_wr & hit(i_addr, OFF_PRIO_UART3);
  wire wr_prio5a    = i_wr & hit(i_addr, OFF_PRIO5A);
  wire wr_prio5b    = i_wr & hit(i_addr, OFF_PRIO5B);
  wire wr_alu_stat  = i_wr & hit(i_addr, OFF_ALU_STATUS);
  wire wr_evt_clr   = i_wr & hit(i_addr, OFF_EVT_CLR);
  wire wr_evt_en    = i_wr & hit(i_addr, OFF_EVT_EN);

  // ****************************************************************
  // external request edge and control fields
  // ****************************************************************

  // edge select: rising by default, falling when the polarity bit is set
  wire ext0_falling   = global_irq_ctrl_b_q[BIT_EXT0_FALL];
  wire ext0_edge      = ext0_falling ? (ext_prev_q & ~i_ext_req0)
                                     : (~ext_prev_q & i_ext_req0);
  wire nesting_disable = global_irq_ctrl_a_q[BIT_NEST_DIS];
  wire [N_TRAP-1:0] trap_flags = global_irq_ctrl_a_q[BIT_TRAP_LO +: N_TRAP];
  wire cpu_level_top_bit = |trap_flags;
  wire [LVL_W-1:0] cpu_level = {cpu_level_top_bit, cpu_priority_level_q};

  // ****************************************************************
  // flag next values: hardware set wins over a software write
  // ****************************************************************
  wire [15:0] set0 = {i_evt_bank0[15:1], i_evt_bank0[0] | ext0_edge};

  assign irq_flags_group0_d = ((wr_flags0 ? i_wdata : irq_flags_group0_q) | set0)
                              & MASK_BANK0;
  assign irq_flags_group5_d = ((wr_flags5 ? i_wdata : irq_flags_group5_q) | i_evt_bank5)
                              & MASK_BANK5;

  // trap status flags: sticky, written value stored, set wins
  wire [15:0] trap_set = {{(15-N_TRAP){1'b0}}, i_trap_evt, 1'b0};
  assign global_irq_ctrl_a_d = ((wr_global_a ? i_wdata : global_irq_ctrl_a_q) | trap_set)
                               & MASK_GLOBAL_A;

  // ****************************************************************
  // per-slot priority map, ascending vector order
  // ****************************************************************
  logic [PRIO_W-1:0] slot_prio [N_SLOT];
  wire  [N_SLOT-1:0] flag_all = {irq_flags_group5_q, irq_flags_group0_q};
  wire  [N_SLOT-1:0] en_all   = {irq_enable_group5_q, irq_enable_group0_q};

  // bank 0: ext request 0, dma channel 1, converter, uart one transmit
  assign slot_prio[0]  = priority_ctrl_group0_q[2:0];
  assign slot_prio[1]  = priority_ctrl_group3_q[10:8];
  assign slot_prio[2]  = priority_ctrl_group3_q[6:4];
  assign slot_prio[3]  = priority_ctrl_group3_q[2:0];
  // bank 5 low: uart three error, receive, transmit
  assign slot_prio[16] = PRIO_OFF;
  assign slot_prio[17] = priority_ctrl_uart_three_q[6:4];
  assign slot_prio[18] = priority_ctrl_uart_three_q[10:8];
  assign slot_prio[19] = priority_ctrl_uart_three_q[14:12];
  // bank 5 high: two-wire collisions, uart four, serial three
  assign slot_prio[20] = priority_ctrl_group5a_q[2:0];
  assign slot_prio[21] = priority_ctrl_group5a_q[6:4];
  assign slot_prio[22] = PRIO_OFF;
  assign slot_prio[23] = priority_ctrl_group5a_q[10:8];
  assign slot_prio[24] = priority_ctrl_group5a_q[14:12];
  assign slot_prio[25] = priority_ctrl_group5b_q[2:0];
  assign slot_prio[26] = priority_ctrl_group5b_q[6:4];
  assign slot_prio[27] = priority_ctrl_group5b_q[10:8];

  // unused slots never request
  generate
    for (genvar g = 4; g < 16; g++)
    begin : g_off0
      assign slot_prio[g] = PRIO_OFF;
    end
    for (genvar g = 28; g < N_SLOT; g++)
    begin : g_off5
      assign slot_prio[g] = PRIO_OFF;
    end
  endgenerate

  // ****************************************************************
  // candidates and arbitration
  // ****************************************************************
  logic [N_SLOT-1:0] cand;

  // flagged, enabled, not disabled, above the current cpu level
  generate
    for (genvar g = 0; g < N_SLOT; g++)
    begin : g_cand
      assign cand[g] = flag_all[g] & en_all[g]
                     & (slot_prio[g] != PRIO_OFF)
                     & ({1'b0, slot_prio[g]} > cpu_level);
    end
  endgenerate

  logic              win_valid;
  logic [PRIO_W-1:0] win_prio;
  logic [4:0]        win_slot;

  // scan down so the lowest slot wins among equal priorities
  always_comb
  begin
    win_valid = 1'b0;
    win_prio  = PRIO_OFF;
    win_slot  = 5'h00;
    for (int s = N_SLOT - 1; s >= 0; s--)
    begin
      if (cand[s] && (slot_prio[s] >= win_prio))
      begin
        win_valid = 1'b1;
        win_prio  = slot_prio[s];
        win_slot  = 5'(s);
      end
    end
  end

  // ****************************************************************
  // cpu level update on acknowledge
  // ****************************************************************

  // nesting disabled raises the level to the top so nothing nests
  assign cpu_priority_level_d = wr_alu_stat ? i_wdata[BIT_LVL_LO +: PRIO_W]
                              : (i_irq_ack & req_q)
                                ? (nesting_disable ? PRIO_MAX : latched_new_level_q[2:0])
                                : cpu_priority_level_q;

  // ****************************************************************
  // controller event status
  // ****************************************************************
  wire [15:0] evt_set = {14'h0000, |i_trap_evt, win_valid & ~req_q};

  // set wins over a clear in the same cycle
  assign evt_stat_d = ((evt_stat_q & ~(wr_evt_clr ? i_wdata : RST_ZERO)) | evt_set) & MASK_EVT;

  // ****************************************************************
  // read mux
  // ****************************************************************
  logic [15:0] rd_mux;

  // unmapped and unimplemented bits read zero
  always_comb
  begin
    rd_mux = RST_ZERO;
    if (hit(i_addr, OFF_GLOBAL_A))   rd_mux = global_irq_ctrl_a_q;
    if (hit(i_addr, OFF_GLOBAL_B))   rd_mux = global_irq_ctrl_b_q;
    if (hit(i_addr, OFF_FLAGS0))     rd_mux = irq_flags_group0_q;
    if (hit(i_addr, OFF_FLAGS5))     rd_mux = irq_flags_group5_q;
    if (hit(i_addr, OFF_ENABLE0))    rd_mux = irq_enable_group0_q;
    if (hit(i_addr, OFF_ENABLE5))    rd_mux = irq_enable_group5_q;
    if (hit(i_addr, OFF_PRIO0))      rd_mux = priority_ctrl_group0_q;
    if (hit(i_addr, OFF_PRIO_GRP3))  rd_mux = priority_ctrl_group3_q;
    if (hit(i_addr, OFF_PRIO_UART3)) rd_mux = priority_ctrl_uart_three_q;
    if (hit(i_addr, OFF_PRIO5A))     rd_mux = priority_ctrl_group5a_q;
    if (hit(i_addr, OFF_PRIO5B))     rd_mux = priority_ctrl_group5b_q;
    if (hit(i_addr, OFF_LATCHED))    rd_mux = {latched_new_level_q, 4'h0,
                                               latched_vector_number_q};
    if (hit(i_addr, OFF_ALU_STATUS)) rd_mux = {8'h00, cpu_priority_level_q, 5'h00};
    if (hit(i_addr, OFF_CORE_CTRL))  rd_mux = {12'h000, cpu_level_top_bit, 3'h0};
    if (hit(i_addr, OFF_EVT_STAT))   rd_mux = evt_stat_q;
    if (hit(i_addr, OFF_EVT_EN))     rd_mux = evt_en_q;
  end

  // ****************************************************************
  // flag and control registers
  // ****************************************************************

  // flags, trap flags and cpu level
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      irq_flags_group0_q   <= RST_ZERO;
      irq_flags_group5_q   <= RST_ZERO;
      global_irq_ctrl_a_q  <= RST_ZERO;
      cpu_priority_level_q <= PRIO_OFF;
      ext_prev_q           <= 1'b0;
    end
    else
    begin
      irq_flags_group0_q   <= irq_flags_group0_d;
      irq_flags_group5_q   <= irq_flags_group5_d;
      global_irq_ctrl_a_q  <= global_irq_ctrl_a_d;
      cpu_priority_level_q <= cpu_priority_level_d;
      ext_prev_q           <= i_ext_req0;
    end
  end

  // software-only configuration registers, masked on write
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      global_irq_ctrl_b_q        <= RST_ZERO;
      irq_enable_group0_q        <= RST_ZERO;
      irq_enable_group5_q        <= RST_ZERO;
      priority_ctrl_group0_q     <= RST_PRIO0;
      priority_ctrl_group3_q     <= RST_PRIO_GRP3;
      priority_ctrl_uart_three_q <= RST_PRIO_UART3;
      priority_ctrl_group5a_q    <= RST_PRIO5A;
      priority_ctrl_group5b_q    <= RST_PRIO5B;
      evt_en_q                   <= RST_ZERO;
    end
    else
    begin
      if (wr_global_b)  global_irq_ctrl_b_q        <= i_wdata & MASK_GLOBAL_B;
      if (wr_enable0)   irq_enable_group0_q        <= i_wdata & MASK_BANK0;
      if (wr_enable5)   irq_enable_group5_q        <= i_wdata & MASK_BANK5;
      if (wr_prio0)     priority_ctrl_group0_q     <= i_wdata & MASK_PRIO0;
      if (wr_prio_grp3) priority_ctrl_group3_q     <= i_wdata & MASK_PRIO_GRP3;
      if (wr_prio_u3)   priority_ctrl_uart_three_q <= i_wdata & MASK_PRIO_UART3;
      if (wr_prio5a)    priority_ctrl_group5a_q    <= i_wdata & MASK_PRIO5A;
      if (wr_prio5b)    priority_ctrl_group5b_q    <= i_wdata & MASK_PRIO5B;
      if (wr_evt_en)    evt_en_q                   <= i_wdata & MASK_EVT;
    end
  end

  // ****************************************************************
  // request latch and bus read data
  // ****************************************************************

  // winner latched every cycle win_valid is high
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      req_q                   <= 1'b0;
      latched_vector_number_q <= 8'h00;
      latched_new_level_q     <= 4'h0;
      evt_stat_q              <= RST_ZERO;
      rdata_q                 <= RST_ZERO;
    end
    else
    begin
      req_q      <= win_valid;
      evt_stat_q <= evt_stat_d;
      rdata_q    <= i_rd ? rd_mux : RST_ZERO;
      if (win_valid)
      begin
        latched_vector_number_q <= vec_of(win_slot);
        latched_new_level_q     <= {1'b0, win_prio};
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_rdata            = rdata_q;
  assign o_irq_req          = req_q;
  assign o_irq_vector       = latched_vector_number_q;
  assign o_irq_level        = latched_new_level_q;
  assign o_cpu_level        = cpu_level;
  assign o_trap_req         = cpu_level_top_bit;
  assign o_alt_vector_table = global_irq_ctrl_b_q[BIT_ALT_TABLE];
  assign o_irq              = |(evt_stat_q & evt_en_q);

endmodule : prioritized_irq_controller
